/* File: hdl/debug_port_access_lock.sv */
// Purpose: decides whether the debug port may be used by a debug tool
// Assumes: nvm answers reads with nvmRdValid and writes with nvmWrDone
// Notes: tck faces the tool; words cross by toggle handshake
// Operation
// [RL1] programmer stores lock signature in nonvolatile memory
// [RL2] signature set: debug refused, boot loader only
// [RL3] boot loader password lets lock be erased
// [RL4] password read from fixed location, 1-4 words; code also accepts length zero as no password
// [RL5] tool presents password before other debug operations
// [RL6] wrong password keeps debug port closed
// [RL7] correct password grants access until brown-out
// [RL8] verified only when every configured word matches
`timescale 1ns/1ps
`include "debug_lock_regs.svh"

module debug_port_access_lock
	import debug_lock_pkg::*;
#(
	parameter int PW_WORDS = `PW_MAX_WORDS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tck,
	input wire logic brownoutResetEvent,
	output nvm_req_s nvmReq,
	input wire logic [15:0] nvmRdData,
	input wire logic nvmRdValid,
	input wire logic nvmWrDone,
	input wire logic bootPwOk,
	input wire logic bootEraseReq,
	input wire logic [15:0] tckPwWord,
	input wire logic tckPwStrobe,
	output logic tckPwReady,
	input wire logic tckOpReq,
	output logic tckOpAccept,
	output logic debugEnable,
	output logic bootMemAccessEn,
	output logic lockFused,
	output logic pwFail
);
	// refuse lengths the index and counter cannot serve
	if (PW_WORDS < 1 || PW_WORDS > `PW_MAX_WORDS) begin : g_chk
		$error("PW_WORDS must be 1 to 4");
	end

	localparam logic [2:0] MAXLEN = 3'(PW_WORDS);

	// ---------------- link domain ----------------
	logic lrS1, lrS2; // reset sync into tck
	logic reqTgl_r; // flips once per word sent
	logic [15:0] wordHold_r; // word held until acknowledged
	logic ackS1, ackS2; // ack toggle sync
	logic grS1, grS2; // grant level sync
	logic ackTgl_r; // clk side ack toggle
	logic grant; // clk side grant level

	// reset synchroniser for the link side
	always_ff @(posedge tck) begin
		lrS1 <= rst_n;
		lrS2 <= lrS1;
	end

	// bring ack and grant into tck
	always_ff @(posedge tck) begin
		ackS1 <= ackTgl_r;
		ackS2 <= ackS1;
		grS1 <= grant;
		grS2 <= grS1;
	end

	// ready when the last word was acknowledged
	assign tckPwReady = lrS2 && (reqTgl_r == ackS2);
	wire sendWord = tckPwStrobe && tckPwReady;

	// capture a word and signal it by toggle
	always_ff @(posedge tck) begin
		if (!lrS2) begin
			reqTgl_r <= 1'b0;
			wordHold_r <= 16'h0000;
		end else if (sendWord) begin
			reqTgl_r <= !reqTgl_r;
			wordHold_r <= tckPwWord;
		end
	end

	// [RL2] [RL5] operations only pass once granted
	assign tckOpAccept = tckOpReq && grS2 && lrS2;

	// ---------------- system domain ----------------
	logic borS1, borS2; // brown-out sync
	logic reqS1, reqS2, reqS3; // word toggle sync and edge
	lock_state_e state_r, state_nxt; // sequencer
	logic [1:0] idx_r, idx_nxt; // password word being loaded
	logic issued_r, issued_nxt; // request sent, answer pending
	logic fused_r, fused_nxt; // signature lock present
	logic [2:0] pwLen_r, pwLen_nxt; // configured password length
	logic [PW_WORDS-1:0][15:0] stored_r; // stored password
	logic [PW_WORDS-1:0][15:0] pres_r; // presented password
	logic [2:0] cnt_r; // presented words so far
	logic check_r; // compare in next cycle
	logic verified_r; // password accepted
	logic pwFail_r; // mismatch pulse
	nvm_req_s req_r, req_nxt; // registered memory request
	logic [PW_WORDS-1:0] matchVec; // per word result

	// brown-out and word toggle synchronisers
	always_ff @(posedge clk) begin
		borS1 <= brownoutResetEvent;
		borS2 <= borS1;
		reqS1 <= reqTgl_r;
		reqS2 <= reqS1;
		reqS3 <= reqS2;
	end

	// [RL7] brown-out re-arms the lock like a reset
	wire lockClr = !rst_n || borS2;
	wire newWord = reqS2 ^ reqS3;
	wire lenZero = (pwLen_r == 3'd0);
	wire [2:0] lenClamp = (nvmRdData[2:0] > MAXLEN) ? MAXLEN : nvmRdData[2:0];
	wire lastLoad = ({1'b0, idx_r} == pwLen_r - 3'd1);
	wire takeWord = newWord && (state_r == S_READY) && !fused_r && !lenZero && !verified_r;
	wire lastWord = (cnt_r == pwLen_r - 3'd1);
	wire allMatch = &matchVec;
	// [RL4] password words at fixed start, word steps
	wire [15:0] pwAddr = `PW_ADDR + (16'(idx_r) * `PW_STEP);
	wire eraseGo = bootEraseReq && bootPwOk && fused_r;

	// sequencer next state and memory requests
	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		issued_nxt = issued_r;
		fused_nxt = fused_r;
		pwLen_nxt = pwLen_r;
		req_nxt = '0;
		unique case (state_r)
			S_SIG: begin
				req_nxt.addr = `SIG_ADDR;
				req_nxt.rd = !issued_r;
				issued_nxt = 1'b1;
				// [RL1] [RL2] signature decides the fuse
				if (issued_r && nvmRdValid) begin
					fused_nxt = (nvmRdData == `SIG_LOCK);
					issued_nxt = 1'b0;
					state_nxt = S_LEN;
				end
			end
			S_LEN: begin
				req_nxt.addr = `LEN_ADDR;
				req_nxt.rd = !issued_r;
				issued_nxt = 1'b1;
				// [RL4] length of zero to four words, zero means no password
				if (issued_r && nvmRdValid) begin
					pwLen_nxt = lenClamp;
					issued_nxt = 1'b0;
					idx_nxt = 2'd0;
					state_nxt = (lenClamp == 3'd0) ? S_READY : S_PW;
				end
			end
			S_PW: begin
				req_nxt.addr = pwAddr;
				req_nxt.rd = !issued_r;
				issued_nxt = 1'b1;
				// next word, or done after the last
				if (issued_r && nvmRdValid) begin
					issued_nxt = 1'b0;
					idx_nxt = idx_r + 2'd1;
					if (lastLoad) begin
						state_nxt = S_READY;
					end
				end
			end
			S_READY: begin
				// [RL3] erase only with boot loader password
				if (eraseGo) begin
					state_nxt = S_ERASE;
				end
			end
			S_ERASE: begin
				req_nxt.addr = `SIG_ADDR;
				req_nxt.wdata = `SIG_ERASED;
				req_nxt.wr = !issued_r;
				issued_nxt = 1'b1;
				// [RL3] lock gone once the write lands
				if (issued_r && nvmWrDone) begin
					fused_nxt = 1'b0;
					issued_nxt = 1'b0;
					state_nxt = S_READY;
				end
			end
			default: begin
				state_nxt = S_SIG;
				issued_nxt = 1'b0;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge clk) begin
		if (lockClr) begin
			state_r <= S_SIG;
			idx_r <= 2'd0;
			issued_r <= 1'b0;
			fused_r <= 1'b1;
			pwLen_r <= 3'd0;
			req_r <= '0;
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			issued_r <= issued_nxt;
			fused_r <= fused_nxt;
			pwLen_r <= pwLen_nxt;
			req_r <= req_nxt;
		end
	end

	// store loaded password words
	always_ff @(posedge clk) begin
		if (lockClr) begin
			stored_r <= '0;
		end else if (state_r == S_PW && issued_r && nvmRdValid) begin
			stored_r[idx_r] <= nvmRdData;
		end
	end

	// collect presented words, acknowledge every word
	always_ff @(posedge clk) begin
		if (lockClr) begin
			ackTgl_r <= 1'b0;
			pres_r <= '0;
			cnt_r <= 3'd0;
			check_r <= 1'b0;
		end else begin
			ackTgl_r <= reqS2;
			check_r <= takeWord && lastWord;
			if (takeWord) begin
				pres_r[cnt_r[1:0]] <= wordHold_r;
				cnt_r <= lastWord ? 3'd0 : cnt_r + 3'd1;
			end
		end
	end

	// [RL8] one comparator per password slot
	for (genvar i = 0; i < PW_WORDS; i++) begin : g_cmp
		pw_compare #(.W(`PW_WIDTH)) u_cmp (
			.enable(3'(i) < pwLen_r),
			.presented(pres_r[i]),
			.stored(stored_r[i]),
			.match(matchVec[i])
		);
	end

	// [RL6] [RL7] verdict is sticky until brown-out
	always_ff @(posedge clk) begin
		if (lockClr) begin
			verified_r <= 1'b0;
			pwFail_r <= 1'b0;
		end else begin
			pwFail_r <= check_r && !allMatch;
			if (check_r && allMatch) begin
				verified_r <= 1'b1;
			end
		end
	end

	// [RL2] debug needs no fuse and a passed password or a zero length
	assign grant = !fused_r && (state_r == S_READY) && (lenZero || verified_r);
	assign debugEnable = grant;
	assign bootMemAccessEn = bootPwOk;
	assign lockFused = fused_r;
	assign pwFail = pwFail_r;
	assign nvmReq = req_r;

	// ---------------- checks ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence sEraseStart;
		state_r == S_READY && eraseGo;
	endsequence

	sequence sEraseDone;
		state_r == S_ERASE && issued_r && nvmWrDone;
	endsequence

	a_fuse_blocks: assert property (fused_r |-> !debugEnable) // RL2
		else $error("debug enabled while fused");
	a_erase_cause: assert property (sEraseStart |=> state_r == S_ERASE ##1 req_r.wr) // RL3
		else $error("erase not started");
	a_erase_clears: assert property (sEraseDone and !borS2 |=> !fused_r ##0 state_r == S_READY) // RL3
		else $error("erase did not clear lock");
	a_pw_address: assert property (req_r.rd && state_r == S_PW |-> req_r.addr >= `PW_ADDR
		&& req_r.addr <= `PW_ADDR + 16'h0006 && !req_r.addr[0]) // RL4
		else $error("password read outside range");
	a_fail_denies: assert property (check_r && !allMatch && !verified_r && !borS2
		|=> pwFail_r && !verified_r) // RL6
		else $error("mismatch granted access");
	a_grant_sticky: assert property (verified_r && !borS2 |=> verified_r) // RL7
		else $error("grant lost without brown-out");
	a_bor_rearms: assert property (borS2 |=> !verified_r && !debugEnable && fused_r) // RL7
		else $error("brown-out did not re-arm");
	a_all_match: assert property (check_r && allMatch && !borS2 |=> verified_r ##1 verified_r) // RL8
		else $error("matching password not accepted");
endmodule

/* File: hdl/debug_lock_regs.svh */
// Purpose: fixed locations, values and sizes of the debug port lock
// Assumes: 16-bit nonvolatile words at even byte addresses
// Notes: included by the package and the top module
`ifndef DEBUG_LOCK_REGS_SVH
`define DEBUG_LOCK_REGS_SVH

// location of the debug port lock signature word
`define SIG_ADDR 16'hff80
// value that, when stored, closes the debug port
`define SIG_LOCK 16'h5555
// value written back when the lock is erased
`define SIG_ERASED 16'hffff
// location of the password length word (low three bits)
`define LEN_ADDR 16'hff84
// first password word
`define PW_ADDR 16'hff88
// byte step between password words
`define PW_STEP 16'h0002
// largest password length in words
`define PW_MAX_WORDS 4
// password word width
`define PW_WIDTH 16

`endif

/* File: hdl/debug_lock_pkg.sv */
// Purpose: types shared by the debug port lock
// Assumes: constants come from debug_lock_regs.svh
// Notes: none
`include "debug_lock_regs.svh"

package debug_lock_pkg;
	// lock sequencer states
	typedef enum logic [2:0] {
		S_SIG = 3'b000,
		S_LEN = 3'b001,
		S_PW = 3'b010,
		S_READY = 3'b011,
		S_ERASE = 3'b100
	} lock_state_e;

	// request to nonvolatile memory
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic rd;
		logic wr;
	} nvm_req_s;
endpackage

/* File: hdl/pw_compare.sv */
// Purpose: compare one presented password word with its stored word
// Assumes: inputs stable while match is used
// Notes: a disabled slot always matches
`timescale 1ns/1ps

module pw_compare #(
	parameter int W = 16
) (
	input wire logic enable,
	input wire logic [W-1:0] presented,
	input wire logic [W-1:0] stored,
	output logic match
);
	// word equal, or slot beyond configured length
	assign match = !enable || (presented == stored);
endmodule

/* File: tb/nvm_model.sv */
// Purpose: behavioural nonvolatile memory behind the debug port lock
// Assumes: one outstanding request, answered one clk later
// Notes: read data is inverted every idle cycle so stale values never look valid
`timescale 1ns/1ps

module nvm_model
	import debug_lock_pkg::*;
(
	input wire logic clk,
	input wire nvm_req_s nvmReq,
	input wire logic clrCnt,
	output logic [15:0] nvmRdData,
	output logic nvmRdValid,
	output logic nvmWrDone,
	output int rdCnt
);
	// word store for 0xff80..0xff8e, loaded by the bench
	logic [15:0] mem [8];
	// word index from byte address
	wire [2:0] idx = nvmReq.addr[3:1];

	initial begin
		nvmRdData = 16'h0000;
		nvmRdValid = 1'b0;
		nvmWrDone = 1'b0;
		rdCnt = 0;
	end

	// stored signature answered
	// answer reads and writes one cycle later, count reads
	always @(posedge clk) begin
		nvmRdValid <= nvmReq.rd;
		nvmWrDone <= nvmReq.wr;
		nvmRdData <= nvmReq.rd ? mem[idx] : ~nvmRdData;
		if (nvmReq.wr) begin
			mem[idx] <= nvmReq.wdata;
		end
		rdCnt <= clrCnt ? 0 : rdCnt + (nvmReq.rd ? 1 : 0);
	end
endmodule

/* File: tb/tb_top.sv */
// Purpose: self-checking bench of the debug port lock
// Assumes: nvm model answers in one cycle, tool words sent after load
// Notes: rows hold memory contents, presented words and expected access
`timescale 1ns/1ps

module tb_top
	import debug_lock_pkg::*;
;
	// one lock configuration and its outcome
	typedef struct packed {
		logic [15:0] sig;
		logic [2:0] len;
		logic [3:0][15:0] pw;
		logic [3:0][15:0] tx;
		logic exp;
	} row_t;

	logic clk = 1'b0;
	logic tck = 1'b0;
	logic rst_n = 1'b0;
	logic brownoutResetEvent = 1'b0;
	logic bootPwOk = 1'b0;
	logic bootEraseReq = 1'b0;
	logic [15:0] tckPwWord = 16'h0000;
	logic tckPwStrobe = 1'b0;
	logic tckOpReq = 1'b1;
	logic clrCnt = 1'b1;
	logic failSeen = 1'b0;
	nvm_req_s nvmReq;
	logic [15:0] nvmRdData;
	logic nvmRdValid, nvmWrDone, tckPwReady, tckOpAccept;
	logic debugEnable, bootMemAccessEn, lockFused, pwFail;
	int error_cnt = 0;
	int num_checks = 0;
	row_t rows [8];

	always #50 clk = ~clk;
	always #3 tck = ~tck;

	// sticky record of a mismatch pulse
	always @(posedge clk) begin
		if (pwFail === 1'b1) begin
			failSeen <= 1'b1;
		end
	end

	debug_port_access_lock dut (.clk(clk), .rst_n(rst_n), .tck(tck),
		.brownoutResetEvent(brownoutResetEvent), .nvmReq(nvmReq), .nvmRdData(nvmRdData),
		.nvmRdValid(nvmRdValid), .nvmWrDone(nvmWrDone), .bootPwOk(bootPwOk),
		.bootEraseReq(bootEraseReq), .tckPwWord(tckPwWord), .tckPwStrobe(tckPwStrobe),
		.tckPwReady(tckPwReady), .tckOpReq(tckOpReq), .tckOpAccept(tckOpAccept),
		.debugEnable(debugEnable), .bootMemAccessEn(bootMemAccessEn),
		.lockFused(lockFused), .pwFail(pwFail));

	nvm_model nvm (.clk(clk), .nvmReq(nvmReq), .clrCnt(clrCnt), .nvmRdData(nvmRdData),
		.nvmRdValid(nvmRdValid), .nvmWrDone(nvmWrDone), .rdCnt());

	// verdict and end of run
	task automatic stop_test();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// compare one value
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// synchronous reset held 4 cycles
	task automatic do_reset();
		@(posedge clk);
		#1 rst_n = 1'b0;
		clrCnt = 1'b1;
		failSeen = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		check(lockFused, 1'b1);
		check(debugEnable, 1'b0);
		rst_n = 1'b1;
		clrCnt = 1'b0;
	endtask

	// bounded wait for a number of memory reads
	task automatic wait_reads(input int n);
		int i;
		for (i = 0; i < 300 && nvm.rdCnt != n; i++) begin
			@(posedge clk);
		end
		if (nvm.rdCnt != n) begin
			error_cnt++;
			stop_test();
		end
		repeat (3) @(posedge clk);
	endtask

	// tool presents one word, held until taken
	task automatic send_word(input logic [15:0] w);
		int i;
		for (i = 0; i < 300 && tckPwReady !== 1'b1; i++) begin
			@(posedge tck);
			#1;
		end
		if (tckPwReady !== 1'b1) begin
			error_cnt++;
			stop_test();
		end
		tckPwWord = w;
		tckPwStrobe = 1'b1;
		@(posedge tck);
		#1 tckPwStrobe = 1'b0;
	endtask

	// load memory, reset, present words, check access
	task automatic run_row(input row_t r);
		int i;
		int n;
		// lengths above four words are served as four
		n = (r.len > 3'h4) ? 4 : int'(r.len);
		nvm.mem[0] = r.sig;
		nvm.mem[2] = {13'h0000, r.len};
		for (i = 0; i < 4; i++) begin
			nvm.mem[4 + i] = r.pw[i];
		end
		do_reset();
		wait_reads(2 + n);
		for (i = 0; i < n; i++) begin
			send_word(r.tx[i]);
		end
		repeat (20) @(posedge clk);
		#1;
		check(debugEnable, r.exp);
		check(tckOpAccept, r.exp);
		check(failSeen, (r.sig == 16'hffff) && (r.len != 0) && !r.exp);
	endtask

	initial begin
		rows[0] = '{16'h5555, 3'h0, 64'h0, 64'h0, 1'b0};
		rows[1] = '{16'hffff, 3'h0, 64'h0, 64'h0, 1'b1};
		rows[2] = '{16'hffff, 3'h2, 64'ha5c3_1234, 64'ha5c3_1234, 1'b1};
		rows[3] = '{16'hffff, 3'h2, 64'ha5c3_1234, 64'ha5c2_1234, 1'b0};
		rows[4] = '{16'hffff, 3'h4, 64'h0f0f_8001_7ffe_c0de, 64'h0f0f_8001_7ffe_c0de, 1'b1};
		rows[5] = '{16'hffff, 3'h1, 64'hbeef, 64'hbeef, 1'b1};
		rows[6] = '{16'h5555, 3'h1, 64'hbeef, 64'hbeef, 1'b0};
		rows[7] = '{16'hffff, 3'h6, 64'h1111_2222_3333_4444, 64'h1111_2222_3333_4444, 1'b1};
		foreach (rows[k]) begin
			run_row(rows[k]);
		end
		// brown-out after a verified password closes the port again
		run_row(rows[4]);
		@(posedge clk);
		#1 brownoutResetEvent = 1'b1;
		clrCnt = 1'b1;
		repeat (4) @(posedge clk);
		#1 brownoutResetEvent = 1'b0;
		clrCnt = 1'b0;
		wait_reads(6);
		#1;
		check(debugEnable, 1'b0);
		// fused part: boot loader path only, then erase of the lock
		run_row(rows[0]);
		@(posedge clk);
		#1 bootPwOk = 1'b1;
		@(posedge clk);
		#1;
		check(bootMemAccessEn, 1'b1);
		check(lockFused, 1'b1);
		bootEraseReq = 1'b1;
		@(posedge clk);
		#1 bootEraseReq = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		check(lockFused, 1'b0);
		check(nvm.mem[0], 16'hffff);
		check(debugEnable, 1'b1);
		check(tckOpAccept, 1'b1);
		// no operation request, nothing accepted
		@(posedge tck);
		#1 tckOpReq = 1'b0;
		#1 check(tckOpAccept, 1'b0);
		stop_test();
	end
endmodule
